// file: logic/stlbs_pkg.sv
// Purpose: shared constants and types of the transmit link bring-up sequencer
// Assumes: one 10 MHz clock; lane count fixed at build time
// Notes:   status pins are bundled into one vector for the synchroniser
package stlbs_pkg;
   // lane count of the transmit link
   localparam int LANES = 4;

   // bit positions inside the synchronised status vector
   localparam int B_CORE   = 0;             // core pll locked
   localparam int B_READY  = 1;             // reset controller tx ready
   localparam int B_CFG    = 2;             // host configuration finished
   localparam int B_DAC    = 3;             // dac programmed over spi
   localparam int B_SYSREF = 4;             // sysref pulse present
   localparam int B_LOCK   = 5;             // first lane pll lock bit
   localparam int B_CAL    = B_LOCK + LANES; // first lane cal busy bit
   localparam int SYNC_W   = B_CAL + LANES;

   // timing: least transceiver reset hold, sysref retry period
   localparam int CLK_PERIOD_NS    = 100;
   localparam int RESET_HOLD_NS    = 1000;
   localparam int RESET_HOLD_CYC   =
      (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYSREF_RETRY_NS  = 100000;
   localparam int SYSREF_RETRY_CYC = SYSREF_RETRY_NS / CLK_PERIOD_NS;
   localparam int CNT_W            = 10;

   // reset values of the synchroniser stages and the captured subclass
   localparam logic SYNC_RST   = 1'b0;
   localparam logic SUBCLASS_0 = 1'b0;

   // sequencer states, gray coded along the bring-up path except the direct S_LINK_K to S_RUN step
   typedef enum logic [2:0] {
      S_XCVR_RST    = 3'h0,
      S_PLL_WAIT    = 3'h1,
      S_READY_WAIT  = 3'h3,
      S_CONFIG      = 3'h2,
      S_LINK_K      = 3'h6,
      S_SYSREF_WAIT = 3'h7,
      S_RUN         = 3'h5
   } stlbs_state_t;
endpackage

// file: logic/stlbs_sync_if.sv
// Purpose: carries raw status pins into the synchroniser and clean ones back
// Assumes: raw bits come from outside the clock domain
// Notes:   one vector, laid out by the package bit positions
`timescale 1ns/1ps
interface stlbs_sync_if
   import stlbs_pkg::*;
   ();
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// file: logic/stlbs_sync.sv
// Purpose: three flip-flop synchroniser with agreement filter for pins
// Assumes: synchronous active high reset
// Notes:   a bit changes only once the second and third stage agree
`timescale 1ns/1ps
module stlbs_sync
   import stlbs_pkg::*;
   (
   // clock and reset
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // status vector
   stlbs_sync_if.sync sif
   );

   logic [SYNC_W-1:0] s1_q;
   logic [SYNC_W-1:0] s2_q;
   logic [SYNC_W-1:0] s3_q;
   logic [SYNC_W-1:0] clean_q;
   logic [SYNC_W-1:0] clean_d;
   logic [SYNC_W-1:0] agree;

   // take the third stage where stages two and three agree, else hold
   assign agree   = ~(s2_q ^ s3_q);
   assign clean_d = (agree & s3_q) | (~agree & clean_q);

   // shift chain, first stage read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q    <= {SYNC_W{SYNC_RST}};
         s2_q    <= {SYNC_W{SYNC_RST}};
         s3_q    <= {SYNC_W{SYNC_RST}};
         clean_q <= {SYNC_W{SYNC_RST}};
      end else begin
         s1_q    <= sif.raw;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         clean_q <= clean_d;
      end
   end

   assign sif.clean = clean_q;
endmodule

// file: logic/stlbs_sequencer.sv
// Purpose: bring-up and reset sequencer for a multi-lane transmit link
// Assumes: status pins asynchronous; outputs drive reset controller and core
// Notes:   any lock or ready loss restarts from the transceiver reset step
`timescale 1ns/1ps
module stlbs_sequencer
   import stlbs_pkg::*;
   (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // status from pll, reset controller, host and clock generator
   input  wire logic             core_pll_locked_i,
   input  wire logic             tx_ready_i,
   input  wire logic             config_done_i,
   input  wire logic             dac_programmed_i,
   input  wire logic             sysref_i,
   input  wire logic [LANES-1:0] lane_pll_locked_i,
   input  wire logic [LANES-1:0] lane_cal_busy_i,
   // static configuration
   input  wire logic             subclass_i,
   input  wire logic             pma_direct_i,
   // resets driven out
   output logic                  xcvr_reset_o,
   output logic [LANES-1:0]      lane_digital_reset_o,
   output logic [LANES-1:0]      lane_analog_reset_o,
   output logic                  config_bus_reset_low_o,
   output logic                  link_reset_low_o,
   output logic                  frame_reset_low_o,
   // link activity and status
   output logic                  send_k_o,
   output logic                  sysref_request_o,
   output logic                  link_up_o,
   output logic [LANES-1:0]      lane_cal_busy_o,
   output logic [LANES-1:0]      phy_clk_en_o,
   output logic [2:0]            state_o
   );

   stlbs_sync_if sif ();
   stlbs_state_t state_q;
   stlbs_state_t state_d;
   logic [CNT_W-1:0]  cnt_q;
   logic              core_ok;
   logic              ready_ok;
   logic              cfg_ok;
   logic              dac_ok;
   logic              sysref_ok;
   logic              lock_ok;
   logic              cal_any;
   logic              lost;
   logic              sub1_q;
   logic              req_q;
   logic              phy_tog_q;
   logic [LANES-1:0]  phy_en_q;
   logic [LANES-1:0]  cal_q;

   // true when every bit of a lane vector is set
   function automatic logic all_set(input logic [LANES-1:0] v);
      all_set = &v;
   endfunction

   // bundle the asynchronous pins for the synchroniser
   assign sif.raw = {lane_cal_busy_i, lane_pll_locked_i, sysref_i,
                     dac_programmed_i, config_done_i, tx_ready_i,
                     core_pll_locked_i};

   stlbs_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .sif   (sif)
   );

   // clean status terms
   assign core_ok   = sif.clean[B_CORE];
   assign ready_ok  = sif.clean[B_READY];
   assign cfg_ok    = sif.clean[B_CFG];
   assign dac_ok    = sif.clean[B_DAC];
   assign sysref_ok = sif.clean[B_SYSREF];
   assign lock_ok   = all_set(sif.clean[B_LOCK +: LANES]);
   assign cal_any   = |sif.clean[B_CAL +: LANES];

   // loss of core lock, lane lock or ready past their own wait states
   always_comb begin
      lost = 1'b0;
      if (state_q != S_XCVR_RST && !core_ok) begin
         lost = 1'b1;
      end
      if (state_q != S_XCVR_RST && state_q != S_PLL_WAIT && !lock_ok) begin
         lost = 1'b1;
      end
      if (state_q inside {S_CONFIG, S_LINK_K, S_SYSREF_WAIT, S_RUN} &&
          !ready_ok) begin
         lost = 1'b1;
      end
   end

   // next state of the bring-up sequence
   always_comb begin
      state_d = state_q;
      if (lost) begin
         state_d = S_XCVR_RST;
      end else begin
         unique case (state_q)
            S_XCVR_RST: begin
               if (core_ok && !cal_any &&
                   cnt_q >= CNT_W'(RESET_HOLD_CYC)) begin
                  state_d = S_PLL_WAIT;
               end
            end
            S_PLL_WAIT: begin
               if (lock_ok) begin
                  state_d = S_READY_WAIT;
               end
            end
            S_READY_WAIT: begin
               if (ready_ok) begin
                  state_d = S_CONFIG;
               end
            end
            S_CONFIG: begin
               if (cfg_ok) begin
                  state_d = S_LINK_K;
               end
            end
            S_LINK_K: begin
               if (sub1_q == SUBCLASS_0 && dac_ok) begin
                  state_d = S_RUN;
               end else if (sub1_q != SUBCLASS_0 && sysref_ok) begin
                  state_d = S_RUN;
               end else if (sub1_q != SUBCLASS_0 && dac_ok) begin
                  state_d = S_SYSREF_WAIT;
               end
            end
            S_SYSREF_WAIT: begin
               if (sysref_ok) begin
                  state_d = S_RUN;
               end
            end
            S_RUN: begin
               state_d = S_RUN;
            end
            default: begin
               state_d = S_XCVR_RST;
            end
         endcase
      end
   end

   // state register; subclass captured while the link is held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_XCVR_RST;
         sub1_q  <= SUBCLASS_0;
      end else begin
         state_q <= state_d;
         if (state_q inside {S_XCVR_RST, S_PLL_WAIT, S_READY_WAIT,
                             S_CONFIG}) begin
            sub1_q <= subclass_i;
         end
      end
   end

   // hold counter in reset state, retry counter while awaiting sysref
   always_ff @(posedge clk_i) begin
      if (rst_i || state_d != state_q) begin
         cnt_q <= '0;
      end else if (state_q == S_SYSREF_WAIT &&
                   cnt_q == CNT_W'(SYSREF_RETRY_CYC - 1)) begin
         cnt_q <= '0;
      end else if (cnt_q != '1) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // one-cycle sysref request on entry and on each retry period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_q <= 1'b0;
      end else begin
         req_q <= state_q == S_SYSREF_WAIT && !sysref_ok &&
                  cnt_q == '0;
      end
   end

   // parallel clock enable: every cycle, or every other in direct pma
   always_ff @(posedge clk_i) begin
      if (rst_i || state_q inside {S_XCVR_RST, S_PLL_WAIT}) begin
         phy_tog_q <= 1'b0;
         phy_en_q  <= '0;
      end else begin
         phy_tog_q <= ~phy_tog_q;
         phy_en_q  <= pma_direct_i ? {LANES{phy_tog_q}} : '1;
      end
   end

   // calibration busy mirrored per lane
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_q <= '0;
      end else begin
         cal_q <= sif.clean[B_CAL +: LANES];
      end
   end

   // outputs decoded from the registered state; cal busy and sysref request come from their own registers, the clock enable is its register gated by state
   assign xcvr_reset_o           = state_q == S_XCVR_RST;
   assign lane_digital_reset_o   = {LANES{state_q == S_XCVR_RST}};
   assign lane_analog_reset_o    = {LANES{state_q == S_XCVR_RST}};
   assign config_bus_reset_low_o = state_q inside {S_CONFIG, S_LINK_K,
                                                   S_SYSREF_WAIT, S_RUN};
   assign link_reset_low_o       = state_q inside {S_LINK_K, S_SYSREF_WAIT,
                                                   S_RUN};
   assign frame_reset_low_o      = link_reset_low_o;
   assign send_k_o               = state_q == S_LINK_K ||
                                   state_q == S_SYSREF_WAIT;
   assign link_up_o              = state_q == S_RUN;
   assign sysref_request_o       = req_q;
   assign lane_cal_busy_o        = cal_q;
   assign phy_clk_en_o           = phy_en_q & {LANES{link_reset_low_o |
                                   (state_q == S_CONFIG) |
                                   (state_q == S_READY_WAIT)}};
   assign state_o                = state_q;

   // checks on the sequence
   core_lock_rel_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(xcvr_reset_o) |-> $past(core_ok))
      else $error("transceiver reset released without core lock");

   pll_wait_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_q == S_PLL_WAIT && !lock_ok |=> state_q != S_READY_WAIT)
      else $error("left pll wait without lane lock");

   cfg_bus_rel_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(config_bus_reset_low_o) |-> $past(ready_ok))
      else $error("config bus reset released before ready");

   link_order_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      link_reset_low_o |-> config_bus_reset_low_o && frame_reset_low_o)
      else $error("link reset released out of order");

   // /K/ must follow release and, one cycle later, continue unless the link is up
   k_stream_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(link_reset_low_o) |-> send_k_o ##1 (send_k_o || link_up_o))
      else $error("no /K/ streaming after link reset release");

   sub0_init_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_q == S_LINK_K && sub1_q == SUBCLASS_0 && dac_ok && !lost
      |=> link_up_o)
      else $error("subclass 0 link did not come up");

   sysref_req_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_q == S_SYSREF_WAIT && !sysref_ok && !lost
      |-> ##[0:1000] sysref_request_o || state_q != S_SYSREF_WAIT)
      else $error("no sysref request while waiting");

   lock_drop_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      link_up_o && !core_ok |=> xcvr_reset_o && !link_reset_low_o)
      else $error("lock loss did not restart sequence");

   lane_reset_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      xcvr_reset_o |-> all_set(lane_digital_reset_o) &&
      all_set(lane_analog_reset_o) && !link_reset_low_o)
      else $error("lane resets not held with transceiver reset");

   // direct pma must have held for two edges before the enable alternates
   phy_half_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      link_up_o && $past(link_up_o, 2) && pma_direct_i &&
      $past(pma_direct_i) && $past(pma_direct_i, 2)
      |-> phy_clk_en_o != $past(phy_clk_en_o))
      else $error("parallel clock enable not halved");
endmodule

// file: sim/stlbs_phy_model.sv
// Purpose: behavioural transceiver reset controller and sysref generator
// Assumes: scenario controls come from the bench at the falling edge
// Notes:   lock and ready follow the sequencer's transceiver reset
`timescale 1ns/1ps
module stlbs_phy_model
   import stlbs_pkg::*;
   #(parameter int LOCK_CYC = 20)
   (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // from the sequencer
   input  wire logic             xcvr_reset_i,
   input  wire logic             sysref_request_i,
   // scenario controls
   input  wire logic [LANES-1:0] cal_i,
   input  wire logic [LANES-1:0] lock_mask_i,
   input  wire logic             sysref_on_i,
   input  wire logic             answer_i,
   // status toward the sequencer
   output logic                  tx_ready_o,
   output logic [LANES-1:0]      lane_pll_locked_o,
   output logic [LANES-1:0]      lane_cal_busy_o,
   output logic                  sysref_o
   );
   int cnt_q;
   int pulse_q;

   // pll and channel stay in reset while held or while calibrating
   always_ff @(negedge clk_i) begin
      if (rst_i || xcvr_reset_i || cal_i != '0) begin
         cnt_q <= 0;
      end else if (cnt_q < LOCK_CYC + 3) begin
         cnt_q <= cnt_q + 1;
      end
   end

   // lock after a delay, ready three cycles later; masked lanes never lock
   // the bonded pll's 6-clock bundle is taken as present on every lane
   assign lane_pll_locked_o =
      (cnt_q >= LOCK_CYC) ? ~lock_mask_i : '0;
   assign tx_ready_o =
      (cnt_q >= LOCK_CYC + 3) && lock_mask_i == '0;
   assign lane_cal_busy_o = cal_i;

   // clock generator answers a request with a pulse a few cycles wide
   always_ff @(negedge clk_i) begin
      if (rst_i) begin
         pulse_q <= 0;
      end else if (sysref_request_i && answer_i) begin
         pulse_q <= 5;
      end else if (pulse_q != 0) begin
         pulse_q <= pulse_q - 1;
      end
   end
   assign sysref_o = sysref_on_i || pulse_q != 0;
endmodule

// file: sim/stlbs_tb_top.sv
// Purpose: self-checking bench for the transmit link bring-up sequencer
// Assumes: 10 MHz clock, inputs driven at the falling edge
// Notes:   expected outputs are decoded from the state reached
`timescale 1ns/1ps
module serial_tx_link_bringup_sequencer_tb_top
   import stlbs_pkg::*;
   ;
   logic             clk, rst, core_lock, cfg_done, dac_done;
   logic             sysref_on, answer, subclass, pma, tx_ready, sysref;
   logic             xcvr_reset, cfg_reset_low, link_reset_low;
   logic             frame_reset_low, send_k, sysref_req, link_up;
   logic [LANES-1:0] cal, lock_mask, lane_lock, lane_cal, lane_cal_busy;
   logic [LANES-1:0] lane_dig, lane_ana, phy_en, pa, pb;
   logic [2:0]       state;
   int               n_errors, n_compared, gap;

   // far side: reset controller and clock generator
   stlbs_phy_model #(.LOCK_CYC(20)) phy (.clk_i(clk), .rst_i(rst),
      .xcvr_reset_i(xcvr_reset), .sysref_request_i(sysref_req),
      .cal_i(cal), .lock_mask_i(lock_mask), .sysref_on_i(sysref_on),
      .answer_i(answer), .tx_ready_o(tx_ready),
      .lane_pll_locked_o(lane_lock), .lane_cal_busy_o(lane_cal),
      .sysref_o(sysref));

   stlbs_sequencer dut (.clk_i(clk), .rst_i(rst),
      .core_pll_locked_i(core_lock), .tx_ready_i(tx_ready),
      .config_done_i(cfg_done), .dac_programmed_i(dac_done),
      .sysref_i(sysref), .lane_pll_locked_i(lane_lock),
      .lane_cal_busy_i(lane_cal), .subclass_i(subclass),
      .pma_direct_i(pma), .xcvr_reset_o(xcvr_reset),
      .lane_digital_reset_o(lane_dig), .lane_analog_reset_o(lane_ana),
      .config_bus_reset_low_o(cfg_reset_low),
      .link_reset_low_o(link_reset_low),
      .frame_reset_low_o(frame_reset_low), .send_k_o(send_k),
      .sysref_request_o(sysref_req), .link_up_o(link_up),
      .lane_cal_busy_o(lane_cal_busy), .phy_clk_en_o(phy_en),
      .state_o(state));

   // clock, 100 ns period; stands for the core pll link clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // compare all reset outputs, send_k and link_up against the given state
   task automatic check_outs(input stlbs_state_t s);
      logic x, c, l;
      x = (s == S_XCVR_RST);
      c = s inside {S_CONFIG, S_LINK_K, S_SYSREF_WAIT, S_RUN};
      l = s inside {S_LINK_K, S_SYSREF_WAIT, S_RUN};
      chk(32'(xcvr_reset), 32'(x));
      chk(32'(lane_dig), 32'({LANES{x}}));
      chk(32'(lane_ana), 32'({LANES{x}}));
      chk(32'(cfg_reset_low), 32'(c));
      chk(32'(link_reset_low), 32'(l));
      chk(32'(frame_reset_low), 32'(l));
      chk(32'(send_k), 32'(s inside {S_LINK_K, S_SYSREF_WAIT}));
      chk(32'(link_up), 32'(s == S_RUN));
      if (s inside {S_XCVR_RST, S_PLL_WAIT}) begin
         chk(32'(phy_en), 32'h0);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // wait a bounded time for a state, then check its outputs
   task automatic wait_state(input stlbs_state_t s);
      int i;
      i = 0;
      while (state !== s && i < 300) begin
         @(negedge clk);
         i++;
      end
      chk(32'(state), 32'(s));
      check_outs(s);
   endtask

   // the state must hold for n cycles
   task automatic stay(input stlbs_state_t s, input int n);
      repeat (n) begin
         @(negedge clk);
         chk(32'(state), 32'(s));
      end
   endtask

   task automatic endtest(input string name);
      $display("test %s done, errors so far %0d", name, n_errors);
   endtask

   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end

   // main sequence
   initial begin
      n_errors = 0;
      n_compared = 0;
      rst = 1'b1;
      core_lock = 1'b0;
      cfg_done = 1'b0;
      dac_done = 1'b0;
      sysref_on = 1'b0;
      answer = 1'b0;
      subclass = 1'b0;
      pma = 1'b0;
      cal = 4'h5;
      lock_mask = 4'h8;
      cyc(3);
      check_outs(S_XCVR_RST);
      rst = 1'b0;
      // calibration and missing core lock keep the transceiver in reset
      cyc(6);
      chk(32'(lane_cal_busy), 32'h5);
      stay(S_XCVR_RST, 20);
      cal = 4'h0;
      stay(S_XCVR_RST, 20);
      core_lock = 1'b1;
      wait_state(S_PLL_WAIT);
      stay(S_PLL_WAIT, 40);
      lock_mask = 4'h0;
      wait_state(S_READY_WAIT);
      wait_state(S_CONFIG);
      endtest("reset_release");
      // configuration phase, then /K/ until the dac is programmed
      stay(S_CONFIG, 20);
      cfg_done = 1'b1;
      wait_state(S_LINK_K);
      stay(S_LINK_K, 20);
      dac_done = 1'b1;
      wait_state(S_RUN);
      endtest("subclass0");
      // parallel clock enable, full and half rate
      cyc(2);
      chk(32'(phy_en), 32'({LANES{1'b1}}));
      pma = 1'b1;
      cyc(5);
      pa = phy_en;
      cyc(1);
      pb = phy_en;
      chk(32'(pa ^ pb), 32'({LANES{1'b1}}));
      pma = 1'b0;
      endtest("phy_clock");
      // core lock loss restarts; subclass 1 without sysref asks for one
      subclass = 1'b1;
      core_lock = 1'b0;
      wait_state(S_XCVR_RST);
      core_lock = 1'b1;
      wait_state(S_SYSREF_WAIT);
      gap = 0;
      while (sysref_req !== 1'b1 && gap < 5) begin
         cyc(1);
         gap++;
      end
      chk(32'(sysref_req), 32'h1);
      cyc(1);
      chk(32'(sysref_req), 32'h0);
      answer = 1'b1;
      gap = 1;
      while (sysref_req !== 1'b1 && gap < 1100) begin
         cyc(1);
         gap++;
      end
      chk(32'(gap >= 990 && gap <= 1010), 32'h1);
      wait_state(S_RUN);
      endtest("sysref_request");
      // lane lock loss drops ready; continuous sysref skips the wait
      answer = 1'b0;
      sysref_on = 1'b1;
      lock_mask = 4'h1;
      wait_state(S_XCVR_RST);
      lock_mask = 4'h0;
      wait_state(S_LINK_K);
      wait_state(S_RUN);
      endtest("lane_loss");
      summarize();
   end
endmodule
